// File: hw/fcl_core.sv
`timescale 1ns/1ps
module fcl_core #(
	parameter int CTRL_CYC = fcl_pkg::CTRL_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic signed [15:0] i_speed_est,
	input wire logic signed [15:0] i_power_meas,
	input wire logic signed [15:0] i_id_meas,
	input wire logic signed [15:0] i_iq_meas,
	input wire logic [15:0] i_duty_cmd,
	input wire logic i_anti_surge_protection,
	output logic signed [15:0] o_vd,
	output logic signed [15:0] o_vq,
	output logic o_overmod_en,
	output logic o_update
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_REF, S_OUTER, S_FW, S_DCUR, S_QCUR, S_DONE} fcl_st_t;
	typedef struct packed {
		fcl_st_t st;
		logic [31:0] div;
		logic [7:0] ctrl;
		logic [31:0] spd_g;
		logic [31:0] cur_g;
		logic [31:0] fw_g;
		logic [31:0] rate;
		logic [31:0] slow;
		logic [31:0] lim;
		logic [31:0] maxes;
		logic [31:0] fwcfg;
		logic [31:0] lead;
		logic [15:0] torque_per_amp_optimisation;
		logic signed [15:0] slew;
		logic signed [15:0] iq_ref;
		logic signed [15:0] id_ref;
		logic signed [15:0] id_fw;
		logic signed [15:0] iq_lim;
		logic signed [15:0] vd;
		logic signed [15:0] vq;
		logic signed [31:0] i_spd;
		logic signed [31:0] i_fw;
		logic signed [31:0] i_d;
		logic signed [31:0] i_q;
		logic spd_lim;
		logic pwr_lim;
		logic fw_act;
		logic sat_spd;
		logic sat_d;
		logic sat_q;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic upd;
	} fcl_state_t;

	fcl_state_t r_ff;
	fcl_state_t nxt_r;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
		if (v > 40'sd32767) begin
			return 16'sh7FFF;
		end else if (v < -40'sd32768) begin
			return -16'sh8000;
		end
		return v[15:0];
	endfunction

	// unsigned fraction times unsigned value, Q16
	function automatic logic [15:0] umul(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] p;
		p = {16'h0, a} * {16'h0, b};
		return p[31:16];
	endfunction

	function automatic logic signed [16:0] diff(input logic signed [15:0] a,
			input logic signed [15:0] b);
		return 17'(a) - 17'(b);
	endfunction

	// ----------------------------------------
	// field views
	// ----------------------------------------
	logic [1:0] mode;
	logic signed [15:0] ilim;
	logic signed [15:0] supply;
	logic signed [15:0] vlim;
	logic signed [15:0] max_spd;
	logic signed [15:0] max_pwr;
	logic signed [15:0] fw_cap;
	logic [31:0] thr2;
	logic [31:0] vs2;
	logic signed [16:0] pi_err;
	logic signed [31:0] pi_integ;
	logic [15:0] pi_kp;
	logic [15:0] pi_ki;
	logic signed [15:0] pi_lo;
	logic signed [15:0] pi_hi;
	logic signed [15:0] pi_out;
	logic signed [31:0] pi_nint;
	logic pi_sat;

	always_comb begin
		mode = r_ff.ctrl[fcl_pkg::CTRL_MODE_LSB +: 2];
		ilim = r_ff.lim[15:0];
		supply = r_ff.lim[31:16];
		// linear range sits below the supply; overmodulation opens it to the full supply
		vlim = r_ff.ctrl[fcl_pkg::CTRL_OVM] ? supply :
			$signed(umul(supply, fcl_pkg::LIN_FRAC));
		max_spd = r_ff.maxes[15:0];
		max_pwr = r_ff.maxes[31:16];
		// zero ratio leaves only the circular limit
		fw_cap = (r_ff.fwcfg[7:0] == 8'h00) ? ilim :
			16'((32'(ilim) * r_ff.fwcfg[7:0]) / fcl_pkg::PCT_FULL);
		thr2 = r_ff.fwcfg[31:16] * r_ff.fwcfg[31:16];
		// compare squares so no root is needed
		vs2 = 32'(r_ff.vd * r_ff.vd) + 32'(r_ff.vq * r_ff.vq);
	end

	// ----------------------------------------
	// shared PI, time-multiplexed by step
	// ----------------------------------------
	always_comb begin
		pi_err = '0;
		pi_integ = '0;
		pi_kp = r_ff.cur_g[15:0];
		pi_ki = r_ff.cur_g[31:16];
		pi_lo = -vlim;
		pi_hi = vlim;
		unique case (r_ff.st)
			S_OUTER: begin
				// power loop borrows the speed gains
				pi_err = (mode == fcl_pkg::MODE_POWER) ? diff(r_ff.slew, i_power_meas) :
					diff(r_ff.slew, i_speed_est);
				pi_integ = r_ff.i_spd;
				pi_kp = r_ff.spd_g[15:0];
				pi_ki = r_ff.spd_g[31:16];
				pi_lo = -r_ff.iq_lim;
				pi_hi = r_ff.iq_lim;
			end
			S_FW: begin
				pi_err = 17'(($signed({1'b0, thr2}) - $signed({1'b0, vs2})) >>> 15);
				pi_integ = r_ff.i_fw;
				pi_kp = r_ff.fw_g[15:0];
				pi_ki = r_ff.fw_g[31:16];
				pi_lo = -fw_cap;
				pi_hi = '0;
			end
			S_DCUR: begin
				pi_err = diff(r_ff.id_ref, i_id_meas);
				pi_integ = r_ff.i_d;
			end
			S_QCUR: begin
				pi_err = diff(r_ff.iq_ref, i_iq_meas);
				pi_integ = r_ff.i_q;
			end
			default: begin
			end
		endcase
	end

	fcl_pi u_pi (
		.i_err(pi_err),
		.i_integ(pi_integ),
		.i_kp(pi_kp),
		.i_ki(pi_ki),
		.i_lo(pi_lo),
		.i_hi(pi_hi),
		.o_out(pi_out),
		.o_integ(pi_nint),
		.o_sat(pi_sat)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic signed [15:0] tgt;
	logic signed [15:0] step;
	logic signed [15:0] id_m;
	logic signed [15:0] id_f;
	logic [15:0] vref;
	logic [31:0] circ;
	logic [47:0] mt;
	logic acc_w;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.upd = 1'b0;
		tgt = '0;
		step = '0;
		id_m = '0;
		id_f = '0;
		vref = '0;
		circ = '0;
		mt = '0;
		acc_w = i_psel && i_penable && r_ff.pready;

		// APB: one wait state, then pready; a write lands on the pready edge
		nxt_r.pready = i_psel && i_penable && !r_ff.pready;
		nxt_r.pslverr = 1'b0;
		if (i_psel && i_penable && !r_ff.pready) begin
			nxt_r.prdata = '0;
			unique case (i_paddr)
				fcl_pkg::OFS_CTRL: nxt_r.prdata = {24'h0, r_ff.ctrl};
				fcl_pkg::OFS_SPD_GAIN: nxt_r.prdata = r_ff.spd_g;
				fcl_pkg::OFS_CUR_GAIN: nxt_r.prdata = r_ff.cur_g;
				fcl_pkg::OFS_FW_GAIN: nxt_r.prdata = r_ff.fw_g;
				fcl_pkg::OFS_RATE: nxt_r.prdata = r_ff.rate;
				fcl_pkg::OFS_SLOW: nxt_r.prdata = r_ff.slow;
				fcl_pkg::OFS_LIMIT: nxt_r.prdata = r_ff.lim;
				fcl_pkg::OFS_MAXES: nxt_r.prdata = r_ff.maxes;
				fcl_pkg::OFS_FW_CFG: nxt_r.prdata = r_ff.fwcfg;
				fcl_pkg::OFS_LEAD: nxt_r.prdata = r_ff.lead;
				fcl_pkg::OFS_TORQUE_PER_AMP_OPTIMISATION: nxt_r.prdata = {16'h0, r_ff.torque_per_amp_optimisation};
				fcl_pkg::OFS_VOUT: nxt_r.prdata = {r_ff.vq, r_ff.vd};
				fcl_pkg::OFS_IREF: nxt_r.prdata = {r_ff.iq_ref, r_ff.id_ref};
				fcl_pkg::OFS_STAT: nxt_r.prdata = {26'h0, r_ff.sat_q, r_ff.sat_d,
					r_ff.sat_spd, r_ff.fw_act, r_ff.pwr_lim, r_ff.spd_lim};
				default: nxt_r.pslverr = 1'b1;
			endcase
		end
		if (acc_w && i_pwrite) begin
			unique case (i_paddr)
				fcl_pkg::OFS_CTRL: nxt_r.ctrl = i_pwdata[7:0];
				fcl_pkg::OFS_SPD_GAIN: nxt_r.spd_g = i_pwdata;
				fcl_pkg::OFS_CUR_GAIN: nxt_r.cur_g = i_pwdata;
				fcl_pkg::OFS_FW_GAIN: nxt_r.fw_g = i_pwdata;
				fcl_pkg::OFS_RATE: nxt_r.rate = i_pwdata;
				fcl_pkg::OFS_SLOW: nxt_r.slow = i_pwdata;
				fcl_pkg::OFS_LIMIT: nxt_r.lim = i_pwdata;
				fcl_pkg::OFS_MAXES: nxt_r.maxes = i_pwdata;
				fcl_pkg::OFS_FW_CFG: nxt_r.fwcfg = i_pwdata;
				fcl_pkg::OFS_LEAD: nxt_r.lead = i_pwdata;
				fcl_pkg::OFS_TORQUE_PER_AMP_OPTIMISATION: nxt_r.torque_per_amp_optimisation = i_pwdata[15:0];
				default: begin
				end
			endcase
		end

		// control-cycle divider
		nxt_r.div = (r_ff.div == 32'(CTRL_CYC - 1)) ? '0 : r_ff.div + 32'h1;

		unique case (r_ff.st)
			S_IDLE: begin
				if (r_ff.div == 32'(CTRL_CYC - 1)) begin
					nxt_r.st = S_REF;
				end
			end
			S_REF: begin
				// voltage reference never drops below the minimum duty
				vref = (i_duty_cmd < r_ff.slow[31:16]) ? r_ff.slow[31:16] : i_duty_cmd;
				unique case (mode)
					fcl_pkg::MODE_SPEED: tgt = $signed(umul(i_duty_cmd, max_spd));
					fcl_pkg::MODE_POWER: tgt = $signed(umul(i_duty_cmd, max_pwr));
					fcl_pkg::MODE_CURRENT: tgt = $signed(umul(i_duty_cmd, ilim));
					fcl_pkg::MODE_VOLT: tgt = $signed(umul(vref, vlim));
				endcase
				nxt_r.spd_lim = r_ff.ctrl[fcl_pkg::CTRL_SPD_LIM] && (i_speed_est >= max_spd);
				nxt_r.pwr_lim = r_ff.ctrl[fcl_pkg::CTRL_PWR_LIM] && (i_power_meas >= max_pwr);
				// other modes have no direct handle on the limited quantity, so back off
				if ((nxt_r.spd_lim && mode != fcl_pkg::MODE_SPEED) ||
						(nxt_r.pwr_lim && mode != fcl_pkg::MODE_POWER)) begin
					if (tgt > sat16(40'(r_ff.slew) - 40'($signed(r_ff.slow[15:0])))) begin
						tgt = sat16(40'(r_ff.slew) - 40'($signed(r_ff.slow[15:0])));
					end
				end
				if (nxt_r.spd_lim || nxt_r.pwr_lim) begin
					step = $signed(r_ff.slow[15:0]);
				end else if (tgt > r_ff.slew) begin
					step = $signed(r_ff.rate[15:0]);
				end else begin
					// anti-surge: slow down braking so the bus is not pumped up
					step = i_anti_surge_protection ? $signed(r_ff.slow[15:0]) :
						$signed(r_ff.rate[31:16]);
				end
				if (tgt > r_ff.slew) begin
					nxt_r.slew = (40'(tgt) - 40'(r_ff.slew) > 40'(step)) ?
						sat16(40'(r_ff.slew) + 40'(step)) : tgt;
				end else begin
					nxt_r.slew = (40'(r_ff.slew) - 40'(tgt) > 40'(step)) ?
						sat16(40'(r_ff.slew) - 40'(step)) : tgt;
				end
				nxt_r.st = S_OUTER;
			end
			S_OUTER: begin
				// circular limit: iq_lim^2 + id_ref^2 tracks ilim^2 one step per cycle
				circ = 32'(r_ff.iq_lim * r_ff.iq_lim) + 32'(r_ff.id_ref * r_ff.id_ref);
				if (circ > 32'(ilim * ilim) || r_ff.iq_lim > ilim) begin
					nxt_r.iq_lim = (r_ff.iq_lim > $signed(fcl_pkg::IQ_LIM_STEP)) ?
						r_ff.iq_lim - $signed(fcl_pkg::IQ_LIM_STEP) : '0;
				end else if (r_ff.iq_lim < ilim) begin
					nxt_r.iq_lim = sat16(40'(r_ff.iq_lim) + 40'(fcl_pkg::IQ_LIM_STEP));
					if (nxt_r.iq_lim > ilim) begin
						nxt_r.iq_lim = ilim;
					end
				end
				nxt_r.st = S_FW;
				unique case (mode)
					fcl_pkg::MODE_SPEED, fcl_pkg::MODE_POWER: begin
						nxt_r.iq_ref = pi_out;
						nxt_r.sat_spd = pi_sat;
						nxt_r.i_spd = pi_nint;
					end
					fcl_pkg::MODE_CURRENT: begin
						nxt_r.iq_ref = (r_ff.slew > r_ff.iq_lim) ? r_ff.iq_lim : r_ff.slew;
						nxt_r.i_spd = '0;
					end
					fcl_pkg::MODE_VOLT: begin
						// loops bypassed; lead angle given as sine/cosine fractions
						nxt_r.vq = $signed(umul(r_ff.slew, r_ff.lead[31:16]));
						nxt_r.vd = -$signed(umul(r_ff.slew, r_ff.lead[15:0]));
						nxt_r.i_spd = '0;
						nxt_r.i_d = '0;
						nxt_r.i_q = '0;
						// no early exit: walking every step keeps the update period fixed
					end
				endcase
			end
			S_FW: begin
				if (!r_ff.ctrl[fcl_pkg::CTRL_FW] || vs2 < thr2) begin
					nxt_r.id_fw = '0;
					nxt_r.i_fw = '0;
					nxt_r.fw_act = 1'b0;
				end else begin
					nxt_r.id_fw = pi_out;
					nxt_r.i_fw = pi_nint;
					nxt_r.fw_act = 1'b1;
				end
				mt = {16'h0, 32'(r_ff.iq_ref * r_ff.iq_ref)} * {32'h0, r_ff.torque_per_amp_optimisation};
				// a zero saliency coefficient gives zero, as for a round rotor
				id_m = sat16(-$signed({1'b0, mt[46:fcl_pkg::TORQUE_PER_AMP_OPTIMISATION_SHIFT]}));
				id_f = nxt_r.id_fw;
				if (r_ff.ctrl[fcl_pkg::CTRL_FW] || r_ff.ctrl[fcl_pkg::CTRL_TORQUE_PER_AMP_OPTIMISATION]) begin
					if (!r_ff.ctrl[fcl_pkg::CTRL_FW]) begin
						id_f = '0;
					end
					if (!r_ff.ctrl[fcl_pkg::CTRL_TORQUE_PER_AMP_OPTIMISATION]) begin
						id_m = '0;
					end
					nxt_r.id_ref = (id_f < id_m) ? id_f : id_m;
				end else begin
					nxt_r.id_ref = '0;
				end
				nxt_r.st = S_DCUR;
			end
			S_DCUR: begin
				// voltage mode already set both outputs; these steps only keep the timing
				if (mode != fcl_pkg::MODE_VOLT) begin
					nxt_r.vd = pi_out;
					nxt_r.sat_d = pi_sat;
					nxt_r.i_d = pi_nint;
				end
				nxt_r.st = S_QCUR;
			end
			S_QCUR: begin
				if (mode != fcl_pkg::MODE_VOLT) begin
					nxt_r.vq = pi_out;
					nxt_r.sat_q = pi_sat;
					nxt_r.i_q = pi_nint;
				end
				nxt_r.st = S_DONE;
			end
			S_DONE: begin
				nxt_r.upd = 1'b1;
				nxt_r.st = S_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_ff <= '0;
			r_ff.spd_g <= fcl_pkg::RST_REG;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign o_prdata = r_ff.prdata;
	assign o_pready = r_ff.pready;
	assign o_pslverr = r_ff.pslverr;
	assign o_vd = r_ff.vd;
	assign o_vq = r_ff.vq;
	assign o_overmod_en = r_ff.ctrl[fcl_pkg::CTRL_OVM];
	assign o_update = r_ff.upd;
endmodule

// File: hw/fcl_pkg.sv
// What this block does
// - id reference zero without weakening or optimisation
// - id reference: zero or minimum of sources
// - reference slews linearly at accel/decel rates
// - speed PI yields iq, clamped to limit
// - speed integrator frozen while output saturated
// - speed error is slewed reference minus estimate
// - d and q PI share one gain pair
// - voltage outputs clamped to linear limit, to supply voltage with overmodulation
// - d controller runs first, checked for saturation
// - current integrator frozen while output saturated
// - overmodulation enable raises voltage beyond linear
// - power mode: reference is duty times maximum
// - voltage mode sets vd, vq from reference
// - voltage reference spans minimum duty to full
// - speed limit restricts reference above maximum speed
// - slow rate while speed limit active
// - power limit restricts reference above maximum power
// - slow rate while power limit active
// - torque-per-amp id from iq and saliency
// - weakening PI with own gains makes id
// - weakening id capped; circular limit trims iq
// - weakening off below modulation index threshold
// - mode 00b is closed-loop speed control
package fcl_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SPD_GAIN = 8'h04;
	localparam logic [7:0] OFS_CUR_GAIN = 8'h08;
	localparam logic [7:0] OFS_FW_GAIN = 8'h0C;
	localparam logic [7:0] OFS_RATE = 8'h10;
	localparam logic [7:0] OFS_SLOW = 8'h14;
	localparam logic [7:0] OFS_LIMIT = 8'h18;
	localparam logic [7:0] OFS_MAXES = 8'h1C;
	localparam logic [7:0] OFS_FW_CFG = 8'h20;
	localparam logic [7:0] OFS_LEAD = 8'h24;
	localparam logic [7:0] OFS_TORQUE_PER_AMP_OPTIMISATION = 8'h28;
	localparam logic [7:0] OFS_VOUT = 8'h2C;
	localparam logic [7:0] OFS_IREF = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h34;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_OVM = 2;
	localparam int CTRL_SPD_LIM = 3;
	localparam int CTRL_PWR_LIM = 4;
	localparam int CTRL_FW = 5;
	localparam int CTRL_TORQUE_PER_AMP_OPTIMISATION = 6;
	localparam logic [1:0] MODE_SPEED = 2'h0;
	localparam logic [1:0] MODE_POWER = 2'h1;
	localparam logic [1:0] MODE_CURRENT = 2'h2;
	localparam logic [1:0] MODE_VOLT = 2'h3;
	localparam logic [31:0] RST_REG = 32'h0;
	// ----------------------------------------
	// arithmetic constants
	// ----------------------------------------
	localparam int GAIN_SHIFT = 8;
	localparam int TORQUE_PER_AMP_OPTIMISATION_SHIFT = 24;
	localparam logic [15:0] LIN_FRAC = 16'hDDB3;
	localparam logic [15:0] IQ_LIM_STEP = 16'h0100;
	localparam logic [15:0] PCT_FULL = 16'h0064;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CTRL_PERIOD_NS = 100000;
	localparam int CTRL_CYC = CTRL_PERIOD_NS * 1000 / CLK_PERIOD_PS;
endpackage

// File: hw/fcl_pi.sv
`timescale 1ns/1ps
// one PI step: the caller keeps the integrator, this computes the next one
module fcl_pi (
	input wire logic signed [16:0] i_err,
	input wire logic signed [31:0] i_integ,
	input wire logic [15:0] i_kp,
	input wire logic [15:0] i_ki,
	input wire logic signed [15:0] i_lo,
	input wire logic signed [15:0] i_hi,
	output logic signed [15:0] o_out,
	output logic signed [31:0] o_integ,
	output logic o_sat
);
	logic signed [39:0] prop;
	logic signed [39:0] inc;
	logic signed [39:0] sum;
	always_comb begin
		prop = 40'($signed({1'b0, i_kp}) * i_err) >>> fcl_pkg::GAIN_SHIFT;
		inc = 40'($signed({1'b0, i_ki}) * i_err) >>> fcl_pkg::GAIN_SHIFT;
		sum = prop + 40'(i_integ);
		o_sat = 1'b0;
		if (sum > 40'(i_hi)) begin
			o_out = i_hi;
			o_sat = 1'b1;
		end else if (sum < 40'(i_lo)) begin
			o_out = i_lo;
			o_sat = 1'b1;
		end else begin
			o_out = sum[15:0];
		end
		// freezing rather than back-calculating keeps the loop cheap
		o_integ = o_sat ? i_integ : 32'(40'(i_integ) + inc);
	end
endmodule

// File: sim/fcl_motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// motor, gate driver and observer stand-in
// ----------------------------------------
// currents and speed follow the last voltage command one control cycle late;
// hold pins speed and power to i_hold_val so the limiters can be driven
module fcl_motor_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic signed [15:0] i_vd,
	input wire logic signed [15:0] i_vq,
	input wire logic i_update,
	input wire logic i_hold_en,
	input wire logic signed [15:0] i_hold_val,
	output logic signed [15:0] o_speed_est,
	output logic signed [15:0] o_power_meas,
	output logic signed [15:0] o_id_meas,
	output logic signed [15:0] o_iq_meas
);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_speed_est <= '0;
			o_power_meas <= '0;
			o_id_meas <= '0;
			o_iq_meas <= '0;
		end else if (i_update) begin
			o_id_meas <= i_vd >>> 3;
			o_iq_meas <= i_vq >>> 3;
			o_speed_est <= i_hold_en ? i_hold_val : i_vq >>> 4;
			o_power_meas <= i_hold_en ? i_hold_val : i_vq >>> 5;
		end
	end
endmodule

// File: sim/fcl_core_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// bus and control-cycle checks
// ----------------------------------------
module fcl_core_asserts #(
	parameter int CTRL_CYC = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic signed [15:0] o_vd,
	input wire logic signed [15:0] o_vq,
	input wire logic o_overmod_en,
	input wire logic o_update
);
	logic [31:0] gap_ff;
	logic seen_ff;
	logic signed [15:0] sup_ff;
	logic wr_ctrl;
	assign wr_ctrl = i_psel && i_penable && i_pwrite && o_pready && i_paddr == fcl_pkg::OFS_CTRL;
	// supply bound follows what software wrote, so the clamp check needs no setup
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			gap_ff <= '0;
			seen_ff <= 1'b0;
			sup_ff <= '0;
		end else begin
			gap_ff <= o_update ? '0 : gap_ff + 32'h1;
			seen_ff <= seen_ff | o_update;
			if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == fcl_pkg::OFS_LIMIT) begin
				sup_ff <= i_pwdata[31:16];
			end
		end
	end
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_setup_access;
		i_psel && !i_penable ##1 i_psel && i_penable;
	endsequence
	AST_READY_WAIT: assert property (s_setup_access |=> o_pready)
		else $error("ready not one cycle into access");
	AST_READY_PULSE: assert property (o_pready |=> !o_pready)
		else $error("ready held two cycles");
	AST_READY_IN_ACCESS: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access");
	AST_ERR_MAP: assert property (o_pready |->
		o_pslverr == (i_paddr > 8'h34 || i_paddr[1:0] != 2'h0))
		else $error("error flag wrong for address");
	AST_ERR_DATA: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
		else $error("error without ready or with data");
	AST_UPDATE_PULSE: assert property (o_update |=> !o_update)
		else $error("update longer than one cycle");
	AST_UPDATE_PERIOD: assert property (o_update && seen_ff |-> gap_ff == CTRL_CYC - 1)
		else $error("control period wrong");
	AST_VOUT_HOLD: assert property ($changed(o_vd) || $changed(o_vq) |-> ##[1:5] o_update)
		else $error("voltage moved outside update");
	AST_SUPPLY_CLAMP: assert property (o_update |-> o_vq <= sup_ff && o_vq >= -sup_ff)
		else $error("vq beyond supply");
	AST_OVM_CAUSE: assert property ($changed(o_overmod_en) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
		else $error("overmodulation flag moved without write");
endmodule

// File: sim/tb_fcl_core.sv
`timescale 1ns/1ps
module tb_fcl_core;
	localparam int CC = 16;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ase = 0, hold = 0, perr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rdata, prdata;
	logic [15:0] duty = 0;
	logic pready, pslverr, ovm, upd;
	logic signed [15:0] vd, vq, spd, pw, idm, iqm;
	int errors = 0, checks_done = 0, cyc = 0;
	always #2.5 clk = ~clk;
	fcl_core #(.CTRL_CYC(CC)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_speed_est(spd), .i_power_meas(pw), .i_id_meas(idm),
		.i_iq_meas(iqm), .i_duty_cmd(duty), .i_anti_surge_protection(ase), .o_vd(vd), .o_vq(vq),
		.o_overmod_en(ovm), .o_update(upd));
	fcl_motor_model mdl (.i_clk(clk), .i_rst_n(rst_n), .i_vd(vd), .i_vq(vq), .i_update(upd),
		.i_hold_en(hold), .i_hold_val(16'sh0200), .o_speed_est(spd), .o_power_meas(pw),
		.o_id_meas(idm), .o_iq_meas(iqm));
	// ----------------------------------------
	// bus, check and closing tasks
	// ----------------------------------------
	task automatic wrap_up;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic ck(input logic ok);
		checks_done++;
		if (ok !== 1'b1) begin
			errors++;
			$display("ERROR t=%0t mismatch at check %0d", $time, checks_done);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		perr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wu(input int n);
		repeat (n) begin
			@(posedge clk);
			while (upd !== 1'b1) @(posedge clk);
		end
	endtask
	// three successive reference steps must all equal the expected rate
	task automatic ramp(input logic signed [15:0] step);
		logic signed [15:0] prev;
		wu(2);
		rd(fcl_pkg::OFS_IREF);
		prev = rdata[31:16];
		repeat (3) begin
			wu(1);
			rd(fcl_pkg::OFS_IREF);
			ck($signed(rdata[31:16]) - prev === step);
			prev = rdata[31:16];
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		for (int a = 0; a <= 8'h34; a += 4) begin
			rd(8'(a));
			ck(rdata === 32'h0 && perr === 1'b0);
		end
		rd(8'h40);
		ck(perr === 1'b1 && rdata === 32'h0);
		wr(fcl_pkg::OFS_VOUT, 32'hFFFF_FFFF);
		rd(fcl_pkg::OFS_VOUT);
		ck(rdata === 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(fcl_pkg::OFS_CTRL, 32'(m));
			rd(fcl_pkg::OFS_CTRL);
			ck(rdata[1:0] === 2'(m));
		end
	endtask
	task automatic t_slew;
		wr(fcl_pkg::OFS_LIMIT, 32'h1000_4000);
		wr(fcl_pkg::OFS_RATE, 32'h0020_0040);
		wr(fcl_pkg::OFS_SLOW, 32'h8000_0010);
		wr(fcl_pkg::OFS_CUR_GAIN, 32'h0100_7FFF);
		duty <= 16'hFFFF;
		wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_CURRENT));
		ramp(16'sh0040);
		ck(rdata[15:0] === 16'h0);
		duty <= 16'h0;
		ramp(-16'sh0020);
		ase <= 1'b1;
		ramp(-16'sh0010);
		ase <= 1'b0;
	endtask
	task automatic t_limits;
		duty <= 16'hFFFF;
		wr(fcl_pkg::OFS_RATE, 32'h0020_0100);
		wu(12);
		wr(fcl_pkg::OFS_MAXES, 32'h0100_0100);
		hold <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_CURRENT) | (32'h8 << k));
			ramp(-16'sh0010);
			rd(fcl_pkg::OFS_STAT);
			ck(rdata[k] === 1'b1);
		end
		hold <= 1'b0;
	endtask
	task automatic t_speed;
		wr(fcl_pkg::OFS_LIMIT, 32'h1000_0800);
		wr(fcl_pkg::OFS_SPD_GAIN, 32'h0100_7FFF);
		wr(fcl_pkg::OFS_MAXES, 32'h7FFF_1000);
		wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_SPEED));
		wu(64);
		rd(fcl_pkg::OFS_IREF);
		ck(rdata === 32'h0800_0000);
		rd(fcl_pkg::OFS_STAT);
		ck(rdata[3] === 1'b1 && rdata[5] === 1'b1);
		ck(vq > 16'sh0 && vq <= 16'sh0DDB);
		wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_SPEED) | 32'h4);
		wu(4);
		ck(ovm === 1'b1 && vq > 16'sh0DDB && vq <= 16'sh1000);
	endtask
	task automatic t_volt;
		wr(fcl_pkg::OFS_LEAD, 32'hFFFF_0000);
		wr(fcl_pkg::OFS_RATE, 32'h7FFF_7FFF);
		duty <= 16'h0;
		wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_VOLT));
		wu(4);
		ck(vd === 16'sh0 && vq >= 16'sh0680 && vq <= 16'sh0700);
	endtask
	task automatic t_fw_torque_per_amp_optimisation;
		duty <= 16'hFFFF;
		wr(fcl_pkg::OFS_FW_GAIN, 32'h0100_0100);
		wr(fcl_pkg::OFS_FW_CFG, 32'h7FFF_0032);
		wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_CURRENT) | 32'h20);
		wu(4);
		rd(fcl_pkg::OFS_STAT);
		ck(rdata[2] === 1'b0);
		rd(fcl_pkg::OFS_IREF);
		ck(rdata[15:0] === 16'h0);
		wr(fcl_pkg::OFS_FW_CFG, 32'h0001_0032);
		wu(8);
		rd(fcl_pkg::OFS_STAT);
		ck(rdata[2] === 1'b1);
		rd(fcl_pkg::OFS_IREF);
		ck($signed(rdata[15:0]) < 0 && $signed(rdata[15:0]) >= -16'sh0400);
		wr(fcl_pkg::OFS_TORQUE_PER_AMP_OPTIMISATION, 32'h0);
		wr(fcl_pkg::OFS_CTRL, 32'(fcl_pkg::MODE_CURRENT) | 32'h40);
		wu(4);
		rd(fcl_pkg::OFS_IREF);
		ck(rdata[15:0] === 16'h0);
		wr(fcl_pkg::OFS_TORQUE_PER_AMP_OPTIMISATION, 32'h0000_0100);
		wu(4);
		rd(fcl_pkg::OFS_IREF);
		ck($signed(rdata[15:0]) < 0);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_slew();
		t_limits();
		t_speed();
		t_volt();
		t_fw_torque_per_amp_optimisation();
		wrap_up();
	end
endmodule
bind fcl_core fcl_core_asserts #(.CTRL_CYC(CTRL_CYC)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_vd(o_vd), .o_vq(o_vq), .o_overmod_en(o_overmod_en), .o_update(o_update));
